// ==== rtl/mem_map.sv ====
// program counter, stack and data-space decoder of a small 8-bit core
// assumes the core drives one access per enabled cycle, synchronous to core_clk_i
`include "mem_map_map.svh"

module mem_map
	import mem_map_pkg::*;
(
	// clock and reset
	input wire logic core_clk_i,
	input wire logic reset_n_i,
	input wire logic clk_en_i,
	// fetch control
	input wire logic fetch_i,
	input wire logic branch_i,
	input wire mem_map_pkg::pc_t branch_target_i,
	input wire logic call_i,
	input wire logic return_i,
	input wire logic irq_accept_i,
	// data access
	input wire logic data_valid_i,
	input wire logic data_write_i,
	input wire logic [6:0] data_addr_i,
	input wire mem_map_pkg::byte_t data_wdata_i,
	// outputs
	output mem_map_pkg::pc_t pc_o,
	output logic [`PROG_IMPL_WIDTH-1:0] prog_addr_o,
	output mem_map_pkg::byte_t data_rdata_o,
	output logic busy_o,
	output logic bank_select_bit_o
);
	import mem_map_pkg::*;

	typedef struct packed {
		pc_t pc;
		logic [`PROG_IMPL_WIDTH-1:0] prog_addr;
		fetch_state_e st;
		logic [2:0] sp;
		byte_t status;
		byte_t pointer;
		byte_t latch;
		byte_t intctl;
		byte_t rdata;
		// one 32-byte page per bank, so plain special offsets never alias across banks
		logic [15:0][31:0] special_store;
	} state_s;

	state_s s_reg, s_next;
	pc_t stack_reg [`STACK_DEPTH];
	byte_t ram_reg [`RAM_WORDS];

	logic [7:0] eff_addr;
	logic ram_hit;
	logic [6:0] ram_idx;
	logic core_hit;
	pc_t pc_plus;

	always_comb begin
		// indirect location redirects through the pointer
		if (data_addr_i == `ADDR_INDIRECT) begin
			eff_addr = s_reg.pointer;
		end else begin
			eff_addr = {s_reg.status[`BANK_SEL_POS], data_addr_i};
		end
		ram_hit = 1'b0;
		ram_idx = 7'h00;
		if (eff_addr >= `RAM0_LO && eff_addr <= `RAM0_HI) begin
			ram_hit = 1'b1;
			ram_idx = eff_addr[6:0];
		end else if (eff_addr >= `RAM1_LO && eff_addr <= `RAM1_HI) begin
			ram_hit = 1'b1;
			// bank 1 ram takes cells 00h-1fh, which bank 0 never reaches, so the shared window stays apart
			ram_idx = {2'b00, eff_addr[4:0]};
		end else if (eff_addr >= `SHARED_LO) begin
			ram_hit = 1'b1;
			ram_idx = {3'b111, eff_addr[3:0]};
		end
		core_hit = (eff_addr[6:0] == `ADDR_PC_LOW) || (eff_addr[6:0] == `ADDR_STATUS) ||
			(eff_addr[6:0] == `ADDR_POINTER) || (eff_addr[6:0] == `ADDR_LATCH) ||
			(eff_addr[6:0] == `ADDR_INTCTL) || (eff_addr[6:0] == `ADDR_INDIRECT);
	end

	assign pc_plus = s_reg.pc + `PC_WIDTH'(1);

	always_comb begin
		s_next = s_reg;
		if (s_reg.st == ST_BRANCH) begin
			s_next.st = ST_EXEC;
		end else if (irq_accept_i) begin
			s_next.pc = `IRQ_VECTOR;
			s_next.sp = s_reg.sp + 3'h1;
			s_next.st = ST_BRANCH;
		end else if (call_i || branch_i) begin
			s_next.pc = branch_target_i;
			s_next.st = ST_BRANCH;
			if (call_i) begin
				s_next.sp = s_reg.sp + 3'h1;
			end
		end else if (return_i) begin
			s_next.pc = stack_reg[s_reg.sp - 3'h1];
			s_next.sp = s_reg.sp - 3'h1;
			s_next.st = ST_BRANCH;
		end else if (fetch_i) begin
			s_next.pc = pc_plus;
			s_next.st = ST_EXEC;
		end
		s_next.prog_addr = s_next.pc[`PROG_IMPL_WIDTH-1:0];
		s_next.rdata = 8'h00;
		if (data_valid_i) begin
			if (core_hit) begin
				case (eff_addr[6:0])
					`ADDR_PC_LOW: s_next.rdata = s_reg.pc[7:0];
					`ADDR_STATUS: s_next.rdata = s_reg.status;
					`ADDR_POINTER: s_next.rdata = s_reg.pointer;
					`ADDR_LATCH: s_next.rdata = s_reg.latch;
					`ADDR_INTCTL: s_next.rdata = s_reg.intctl;
					default: s_next.rdata = 8'h00;
				endcase
				if (data_write_i) begin
					case (eff_addr[6:0])
						`ADDR_PC_LOW: begin
							s_next.pc = {s_reg.latch[4:0], data_wdata_i};
							s_next.prog_addr = s_next.pc[`PROG_IMPL_WIDTH-1:0];
							s_next.st = ST_BRANCH;
						end
						`ADDR_STATUS: s_next.status = data_wdata_i;
						`ADDR_POINTER: s_next.pointer = data_wdata_i;
						`ADDR_LATCH: s_next.latch = {3'b000, data_wdata_i[4:0]};
						`ADDR_INTCTL: s_next.intctl = data_wdata_i;
						default: s_next.latch = s_reg.latch;
					endcase
				end
			end else if (eff_addr[6:0] < `SPECIAL_LIMIT) begin
				s_next.rdata = s_reg.special_store[{eff_addr[7], eff_addr[4:2]}][8*eff_addr[1:0] +: 8];
				if (data_write_i) begin
					s_next.special_store[{eff_addr[7], eff_addr[4:2]}][8*eff_addr[1:0] +: 8] = data_wdata_i;
				end
			end else if (ram_hit) begin
				s_next.rdata = ram_reg[ram_idx];
			end
		end
	end

	always_ff @(posedge core_clk_i) begin
		if (!reset_n_i) begin
			s_reg <= '0;
			s_reg.pc <= `RESET_VECTOR;
			s_reg.st <= ST_IDLE;
			s_reg.status <= 8'h18;
		end else if (clk_en_i) begin
			s_reg <= s_next;
		end
	end

	// arrays sit outside the struct; reset is not needed for ram contents
	always_ff @(posedge core_clk_i) begin
		if (reset_n_i && clk_en_i) begin
			if (data_valid_i && data_write_i && ram_hit && !core_hit) begin
				ram_reg[ram_idx] <= data_wdata_i;
			end
			// an interrupt outranks a branch in the same cycle and must still push
			if (s_reg.st != ST_BRANCH && (irq_accept_i || call_i)) begin
				stack_reg[s_reg.sp] <= irq_accept_i ? s_reg.pc : pc_plus;
			end
		end
	end

	assign pc_o = s_reg.pc;
	assign prog_addr_o = s_reg.prog_addr;
	assign data_rdata_o = s_reg.rdata;
	assign busy_o = s_reg.st[2];
	assign bank_select_bit_o = s_reg.status[`BANK_SEL_POS];

	a_reset_vector: assert property (@(posedge core_clk_i) $rose(reset_n_i) |-> pc_o == `RESET_VECTOR)
		else $error("pc not at reset vector");
	a_irq_vector: assert property (@(posedge core_clk_i) disable iff (!reset_n_i)
		clk_en_i && irq_accept_i && !busy_o |=> pc_o == `IRQ_VECTOR)
		else $error("interrupt did not reach vector");
	a_prog_fold: assert property (@(posedge core_clk_i) disable iff (!reset_n_i)
		prog_addr_o == pc_o[`PROG_IMPL_WIDTH-1:0])
		else $error("program address not folded");
	a_fetch_step: assert property (@(posedge core_clk_i) disable iff (!reset_n_i)
		clk_en_i && fetch_i && !busy_o && !irq_accept_i && !branch_i && !call_i && !return_i
		&& !data_valid_i |=> pc_o == $past(pc_o) + 13'h0001)
		else $error("fetch did not advance pc");
	a_branch_slow: assert property (@(posedge core_clk_i) disable iff (!reset_n_i)
		clk_en_i && branch_i && !busy_o && !irq_accept_i |=> busy_o)
		else $error("branch took one cycle");
	a_unmapped_zero: assert property (@(posedge core_clk_i) disable iff (!reset_n_i)
		clk_en_i && data_valid_i && !ram_hit && eff_addr[6:0] >= `SPECIAL_LIMIT |=> data_rdata_o == 8'h00)
		else $error("unmapped read not zero");
	a_bank_bit: assert property (@(posedge core_clk_i) disable iff (!reset_n_i)
		data_addr_i != `ADDR_INDIRECT |-> eff_addr[7] == bank_select_bit_o)
		else $error("bank bit not applied");
	a_core_mirror: assert property (@(posedge core_clk_i) disable iff (!reset_n_i)
		clk_en_i && data_valid_i && !data_write_i && eff_addr[6:0] == `ADDR_POINTER |=>
		data_rdata_o == $past(s_reg.pointer))
		else $error("pointer mirror wrong");

	// reset and control timing
	a_reset_state: assert property (@(posedge core_clk_i) !reset_n_i |=>
		pc_o == `RESET_VECTOR && !busy_o && data_rdata_o == 8'h00)
		else $error("reset state wrong");
	a_call_slow: assert property (@(posedge core_clk_i) disable iff (!reset_n_i)
		clk_en_i && call_i && !busy_o && !irq_accept_i |=> busy_o)
		else $error("call took one cycle");
	a_return_slow: assert property (@(posedge core_clk_i) disable iff (!reset_n_i)
		clk_en_i && return_i && !busy_o && !irq_accept_i && !call_i && !branch_i |=> busy_o)
		else $error("return took one cycle");

	// data space decode
	a_bank1_ram: assert property (@(posedge core_clk_i) disable iff (!reset_n_i)
		ram_hit && eff_addr >= `RAM1_LO && eff_addr <= `RAM1_HI |-> ram_idx < 7'h20)
		else $error("bank 1 ram overlaps other cells");
	a_shared_cell: assert property (@(posedge core_clk_i) disable iff (!reset_n_i)
		ram_hit && eff_addr >= `SHARED_LO |-> ram_idx == eff_addr[6:0])
		else $error("shared window off its cells");
	a_bank_write: assert property (@(posedge core_clk_i) disable iff (!reset_n_i)
		clk_en_i && data_valid_i && data_write_i && eff_addr[6:0] == `ADDR_STATUS |=>
		bank_select_bit_o == $past(data_wdata_i[`BANK_SEL_POS]))
		else $error("bank bit not written");

	c_irq: cover property (@(posedge core_clk_i) irq_accept_i && clk_en_i);
	c_shared: cover property (@(posedge core_clk_i) data_valid_i && eff_addr >= `SHARED_LO);
	c_indirect: cover property (@(posedge core_clk_i) data_valid_i && data_addr_i == `ADDR_INDIRECT);
	c_return: cover property (@(posedge core_clk_i) return_i && clk_en_i && !busy_o);
	c_bank1_ram: cover property (@(posedge core_clk_i) data_valid_i && ram_hit && eff_addr[7] && eff_addr < `SHARED_LO);
endmodule

// ==== rtl/mem_map_map.svh ====
// address map constants for the core memory decoder
// assumes inclusion by the package and the decoder only
`ifndef MEM_MAP_MAP_SVH
`define MEM_MAP_MAP_SVH
`define PC_WIDTH 13
`define PROG_IMPL_WIDTH 11
`define RESET_VECTOR 13'h0000
`define IRQ_VECTOR 13'h0004
`define BANK_SEL_POS 5
`define SPECIAL_LIMIT 7'h20
`define RAM0_LO 8'h20
`define RAM0_HI 8'h7f
`define RAM1_LO 8'ha0
`define RAM1_HI 8'hbf
`define SHARED_LO 8'hf0
`define SHARED_HI 8'hff
`define SHARED_BASE 8'h70
`define ADDR_INDIRECT 7'h00
`define ADDR_PC_LOW 7'h02
`define ADDR_STATUS 7'h03
`define ADDR_POINTER 7'h04
`define ADDR_LATCH 7'h0a
`define ADDR_INTCTL 7'h0b
`define RAM_WORDS 128
`define STACK_DEPTH 8
`define BRANCH_CYCLES 2
`endif

// ==== rtl/mem_map_pkg.sv ====
// types for the core memory decoder
// assumes the map header is on the include path
`include "mem_map_map.svh"
package mem_map_pkg;
	typedef logic [`PC_WIDTH-1:0] pc_t;
	typedef logic [7:0] byte_t;
	typedef enum logic [2:0] {
		ST_IDLE = 3'b001,
		ST_EXEC = 3'b010,
		ST_BRANCH = 3'b100
	} fetch_state_e;
endpackage

// ==== testbench/core_model.sv ====
// cpu core stand-in: control pulses and data accesses for the decoder
// assumes the decoder samples on the rising edge of core_clk_i
module core_model
	import mem_map_pkg::*;
(
	// clock and answers
	input wire logic core_clk_i,
	input wire mem_map_pkg::byte_t data_rdata_i,
	input wire logic busy_i,
	// requests
	output logic [4:0] ctl_o,
	output mem_map_pkg::pc_t target_o,
	output logic valid_o,
	output logic write_o,
	output logic [6:0] addr_o,
	output mem_map_pkg::byte_t wdata_o
);
	timeunit 1ns;
	timeprecision 1ps;
	logic bank;
	initial begin
		{ctl_o, target_o, valid_o, write_o, addr_o, wdata_o, bank} = '0;
	end
	// a spare cycle follows each pulse, since control is ignored while busy
	task automatic ctl(input int k, input pc_t t, output logic b);
		@(negedge core_clk_i);
		ctl_o[k] = 1'b1;
		target_o = t;
		@(negedge core_clk_i);
		b = busy_i;
		ctl_o[k] = 1'b0;
		@(negedge core_clk_i);
	endtask
	task automatic raw(input logic w, input logic [6:0] a, input byte_t d, output byte_t r);
		@(negedge core_clk_i);
		{valid_o, write_o, addr_o, wdata_o} = {1'b1, w, a, d};
		@(negedge core_clk_i);
		r = data_rdata_i;
		valid_o = 1'b0;
	endtask
	task automatic acc(input logic w, input byte_t a, input byte_t d, output byte_t r);
		if (a[7] != bank) begin
			raw(1'b1, 7'h03, {2'b00, a[7], 5'h18}, r);
			bank = a[7];
		end
		raw(w, a[6:0], d, r);
	endtask
endmodule

// ==== testbench/mem_map_tb.sv ====
// self-checking bench for the memory decoder
// assumes core_model drives every request
`define CHK(a, b) begin checks++; if ((a) !== (b)) begin err_count++; $display("ERROR %0t got %h want %h", $time, a, b); end end
module mem_map_tb
	import mem_map_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;
	logic core_clk_i = 1'b0;
	logic reset_n_i = 1'b0;
	logic en = 1'b1;
	logic [4:0] ctl;
	logic valid, write, busy, bsel, b;
	logic [6:0] addr;
	byte_t wdata, rd, r, d, a;
	pc_t target, pc, t, cur;
	logic [10:0] pa;
	int err_count = 0, checks = 0, seed = 87486;
	byte_t sh[byte_t];
	pc_t q[$];
	always #20 core_clk_i = ~core_clk_i;
	core_model core_model_inst (.core_clk_i(core_clk_i), .data_rdata_i(rd), .busy_i(busy), .ctl_o(ctl),
		.target_o(target), .valid_o(valid), .write_o(write), .addr_o(addr), .wdata_o(wdata));
	mem_map mem_map_inst (.core_clk_i(core_clk_i), .reset_n_i(reset_n_i), .clk_en_i(en), .fetch_i(ctl[0]),
		.branch_i(ctl[1]), .branch_target_i(target), .call_i(ctl[2]), .return_i(ctl[3]), .irq_accept_i(ctl[4]),
		.data_valid_i(valid), .data_write_i(write), .data_addr_i(addr), .data_wdata_i(wdata), .pc_o(pc),
		.prog_addr_o(pa), .data_rdata_o(rd), .busy_o(busy), .bank_select_bit_o(bsel));
	function automatic logic [10:0] fold(pc_t p);
		return p[10:0];
	endfunction
	task automatic rc(input byte_t ad, input byte_t e);
		core_model_inst.acc(1'b0, ad, 8'h00, r);
		`CHK(r, e)
	endtask
	task automatic report_and_stop();
		$display("checks %0d errors %0d", checks, err_count);
		if (err_count == 0 && checks > 0) $display("Test passed");
		else $display("Test failed");
		$finish;
	endtask
	initial begin
		#(40 * 4000);
		err_count++;
		report_and_stop();
	end
	initial begin
		repeat (2) @(negedge core_clk_i);
		reset_n_i = 1'b1;
		`CHK(pc, 13'h0000)
		`CHK(bsel, 1'b0)
		core_model_inst.ctl(0, 13'h0000, b);
		`CHK(pc, 13'h0001)
		`CHK(b, 1'b0)
		// a fetch while the enable is low must leave the counter alone
		en = 1'b0;
		core_model_inst.ctl(0, 13'h0000, b);
		`CHK(pc, 13'h0001)
		en = 1'b1;
		for (int i = 0; i < 4; i++) begin
			t = (i == 0) ? 13'h1fff : pc_t'($random(seed));
			core_model_inst.ctl(1, t, b);
			`CHK(pc, t)
			`CHK(pa, fold(t))
			`CHK(b, 1'b1)
			cur = t;
		end
		// seven calls plus the interrupt fill the eight entries exactly
		for (int i = 0; i < 7; i++) begin
			q.push_back(cur + 13'h0001);
			cur = pc_t'($random(seed));
			core_model_inst.ctl(2, cur, b);
		end
		core_model_inst.ctl(4, 13'h0000, b);
		`CHK(pc, 13'h0004)
		for (int i = 0; i < 8; i++) begin
			core_model_inst.ctl(3, 13'h0000, b);
			if (i > 0) cur = q.pop_back();
			`CHK(pc, cur)
		end
		rc(8'h03, 8'h18);
		for (int i = 0; i < 24; i++) begin
			a = 8'h20 + (byte_t'($random(seed)) & 8'h5f);
			d = byte_t'($random(seed));
			core_model_inst.acc(1'b1, a, d, r);
			sh[a] = d;
		end
		foreach (sh[k]) rc(k, sh[k]);
		core_model_inst.acc(1'b1, 8'h04, 8'h30, r);
		core_model_inst.acc(1'b1, 8'h30, 8'hc3, r);
		rc(8'h00, 8'hc3);
		core_model_inst.acc(1'b1, 8'h11, 8'h6e, r);
		rc(8'h11, 8'h6e);
		core_model_inst.acc(1'b1, 8'h81, 8'h99, r);
		rc(8'h11, 8'h6e);
		rc(8'h81, 8'h99);
		core_model_inst.acc(1'b1, 8'h78, 8'h5a, r);
		rc(8'hf8, 8'h5a);
		`CHK(bsel, 1'b1)
		rc(8'hc3, 8'h00);
		core_model_inst.acc(1'b1, 8'ha5, 8'h3c, r);
		rc(8'ha5, 8'h3c);
		core_model_inst.acc(1'b1, 8'hb8, 8'he1, r);
		rc(8'hf8, 8'h5a);
		rc(8'hb8, 8'he1);
		rc(8'h84, 8'h30);
		core_model_inst.acc(1'b1, 8'h8a, 8'h15, r);
		rc(8'h0a, 8'h15);
		// second reset in mid-run
		reset_n_i = 1'b0;
		repeat (2) @(negedge core_clk_i);
		reset_n_i = 1'b1;
		`CHK(pc, 13'h0000)
		`CHK(bsel, 1'b0)
		report_and_stop();
	end
endmodule
